/* core/dttr_pkg.sv */
// Constants and types shared by the acquisition trigger and timing router
package dttr_pkg;

    // ********************************************************
    // Clocking and pulse timing
    // ********************************************************
    localparam int CLK_HZ           = 250_000_000;
    localparam int BASE_HZ          = 10_000_000;
    localparam int TICK_DIV         = CLK_HZ / BASE_HZ;
    localparam int TICK_W           = 5;
    localparam int BASE_PERIOD_NS   = 1_000_000_000 / BASE_HZ;
    localparam int MARKER_LOW_NS    = 1000;
    localparam int MARKER_TICKS     = MARKER_LOW_NS / BASE_PERIOD_NS;
    localparam int STROBE_NS        = 300;
    localparam int STROBE_TICKS     = STROBE_NS / BASE_PERIOD_NS;
    localparam int CONV_PULSE_NS    = 100;
    localparam int CONV_PULSE_TICKS = CONV_PULSE_NS / BASE_PERIOD_NS;
    localparam int TMR_W            = 4;

    // ********************************************************
    // Counters
    // ********************************************************
    localparam int SAMPLE_W   = 32;
    localparam int CNT_LOW_W  = 16;
    localparam int INTERVAL_W = 16;

    // ********************************************************
    // Crossbar
    // ********************************************************
    localparam int XB_LINES       = 7;
    localparam int XB_IDX_W       = 3;
    localparam int PROG_SIDE_BIT  = 3;
    localparam int XB_PIN_COUNTER1_GATE_LINE   = 0;
    localparam int XB_PIN_COUNTER1_OUTPUT    = 1;
    localparam int XB_PIN_CONV    = 2;
    localparam int XB_PIN_START   = 3;
    localparam int XB_PIN_FREQ_DIVIDER_OUTPUT    = 4;
    localparam int XB_PIN_POST    = 5;
    localparam int XB_PIN_COUNTER5_COUNT_INPUT = 6;

    typedef struct packed {
        logic                enable;
        logic [XB_IDX_W-1:0] source;
    } dttr_route_s;

    localparam dttr_route_s ROUTE_RESET = '0;

    typedef struct packed {
        logic ext_conv_mode;
        logic pretrig_mode;
        logic scan_enable;
        logic cascade;
    } dttr_acq_cfg_s;

    typedef enum logic [1:0] {
        ACQ_IDLE  = 2'b00,
        ACQ_ARMED = 2'b01,
        ACQ_RUN   = 2'b10
    } dttr_acq_e;

endpackage

/* core/dttr_sync_edge.sv */
// Two-stage input synchroniser with edge detection
`timescale 1ns/1ps
module dttr_sync_edge #(
    parameter int         W       = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         mclk_in,
    input  wire logic         rstn_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] level_out,
    output logic      [W-1:0] rise_out,
    output logic      [W-1:0] fall_out
);
    import dttr_pkg::*;

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] prev_reg;

    // Stage one feeds only stage two
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
            prev_reg <= RST_VAL;
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign level_out = sync_reg;
    assign rise_out  = sync_reg & ~prev_reg;
    assign fall_out  = ~sync_reg & prev_reg;
endmodule

/* core/dttr_xbar.sv */
// Programmable crossbar between board timing signals and shared trigger lines
`timescale 1ns/1ps
module dttr_xbar #(
    parameter int LINES = dttr_pkg::XB_LINES
) (
    input  wire logic                  mclk_in,
    input  wire logic                  rstn_in,
    input  wire logic [3:0]            prog_sel_in,
    input  dttr_pkg::dttr_route_s      prog_data_in,
    input  wire logic                  prog_wr_in,
    input  wire logic [LINES-1:0]      board_in,
    input  wire logic [LINES-1:0]      bus_in,
    output logic      [LINES-1:0]      bus_out,
    output logic      [LINES-1:0]      bus_oe_n_out,
    output logic      [LINES-1:0]      board_out,
    output logic      [LINES-1:0]      board_oe_n_out
);
    import dttr_pkg::*;

    if (LINES < 1 || LINES > (1 << XB_IDX_W)) begin : g_chk
        $error("dttr_xbar: LINES out of range");
    end

    function automatic logic sel_hit(logic [3:0] sel, logic side, int idx);
        return sel[PROG_SIDE_BIT] == side && sel[XB_IDX_W-1:0] == XB_IDX_W'(idx);
    endfunction

    dttr_route_s bus_route_reg   [LINES];
    dttr_route_s board_route_reg [LINES];
    logic        src_ok;

    // Out-of-range sources are dropped so no line reads past the array
    assign src_ok = 32'(prog_data_in.source) < LINES;

    for (genvar i = 0; i < LINES; i++) begin : g_line
        always_ff @(posedge mclk_in) begin
            if (!rstn_in) begin
                bus_route_reg[i] <= ROUTE_RESET;
            end else if (prog_wr_in && src_ok && sel_hit(prog_sel_in, 1'b0, i)) begin
                bus_route_reg[i] <= prog_data_in;
            end
        end

        always_ff @(posedge mclk_in) begin
            if (!rstn_in) begin
                board_route_reg[i] <= ROUTE_RESET;
            end else if (prog_wr_in && src_ok && sel_hit(prog_sel_in, 1'b1, i)) begin
                board_route_reg[i] <= prog_data_in;
            end
        end

        // Registered paths break any loop through the far boards
        always_ff @(posedge mclk_in) begin
            if (!rstn_in) begin
                bus_out[i]        <= 1'b1;
                bus_oe_n_out[i]   <= 1'b1;
                board_out[i]      <= 1'b1;
                board_oe_n_out[i] <= 1'b1;
            end else begin
                bus_out[i]        <= board_in[bus_route_reg[i].source];
                bus_oe_n_out[i]   <= ~bus_route_reg[i].enable;
                board_out[i]      <= bus_in[board_route_reg[i].source];
                board_oe_n_out[i] <= ~board_route_reg[i].enable;
            end
        end
    end
endmodule

/* core/dttr_top.sv */
// Acquisition trigger, conversion timing and trigger-line routing
`timescale 1ns/1ps
module dttr_top #(
    parameter int SMP_W = dttr_pkg::SAMPLE_W,
    parameter int IVL_W = dttr_pkg::INTERVAL_W
) (
    input  wire logic                       mclk_in,
    input  wire logic                       rstn_in,
    input  dttr_pkg::dttr_acq_cfg_s         acq_cfg_in,
    input  wire logic                       arm_in,
    input  wire logic                       adc_clear_in,
    input  wire logic                       overflow_in,
    input  wire logic                       overrun_in,
    input  wire logic [SMP_W-1:0]           sample_count_in,
    input  wire logic [IVL_W-1:0]           interval_in,
    input  wire logic                       strobe_access_in,
    input  wire logic                       conversion_request_in_n,
    input  wire logic                       acq_begin_trigger_n_in,
    input  wire logic                       posttrigger_arm_in,
    input  wire logic                       counter1_gate_line_in,
    input  wire logic                       counter1_output_in,
    input  wire logic                       counter2_output_in,
    input  wire logic                       counter5_output_in,
    input  wire logic                       freq_divider_output_in,
    input  wire logic [3:0]                 xb_prog_sel_in,
    input  dttr_pkg::dttr_route_s           xb_prog_data_in,
    input  wire logic                       xb_prog_wr_in,
    input  wire logic [dttr_pkg::XB_LINES-1:0] trig_bus_in,
    output logic [dttr_pkg::XB_LINES-1:0]   trig_bus_out,
    output logic [dttr_pkg::XB_LINES-1:0]   trig_bus_oe_n_out,
    output logic [dttr_pkg::XB_LINES-1:0]   board_pin_out,
    output logic [dttr_pkg::XB_LINES-1:0]   board_pin_oe_n_out,
    output logic                            conv_line_out,
    output logic                            conv_line_oe_n_out,
    output logic                            conversion_marker_out,
    output logic                            host_strobe_pulse_n_out,
    output logic                            conversion_start_out,
    output logic                            counter4_gate_line_out,
    output logic                            acq_busy_out,
    output logic                            acq_armed_out,
    output logic                            acq_done_out,
    output logic [SMP_W-1:0]                sample_left_out,
    output logic                            tick_out
);
    import dttr_pkg::*;

    if (SMP_W <= CNT_LOW_W || IVL_W < 2 || TICK_DIV > (1 << TICK_W)) begin : g_chk
        $error("dttr_top: parameter out of range");
    end

    localparam logic [TICK_W-1:0] TICK_LAST  = TICK_W'(TICK_DIV - 1);
    localparam logic [TMR_W-1:0]  MARK_LEN   = TMR_W'(MARKER_TICKS);
    localparam logic [TMR_W-1:0]  STRB_LEN   = TMR_W'(STROBE_TICKS);
    localparam logic [TMR_W-1:0]  CPULSE_LEN = TMR_W'(CONV_PULSE_TICKS);

    // ********************************************************
    // 10 MHz timing tick
    // ********************************************************
    logic [TICK_W-1:0] tick_cnt_reg;
    logic              tick_reg;

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
        end else if (tick_cnt_reg == TICK_LAST) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
            tick_reg     <= 1'b0;
        end
    end

    assign tick_out = tick_reg;

    // ********************************************************
    // Trigger crossbar and shared board pins
    // ********************************************************
    logic [XB_LINES-1:0] board_sig;
    logic                conv_n_raw;
    logic                start_n_raw;
    logic                post_raw;

    // Conv and start pins combine as the wired level a pull-up would give; post is ORed with its driven-high pin
    assign conv_n_raw  = conversion_request_in_n
                         & (board_pin_oe_n_out[XB_PIN_CONV] | board_pin_out[XB_PIN_CONV]);
    assign start_n_raw = acq_begin_trigger_n_in
                         & (board_pin_oe_n_out[XB_PIN_START] | board_pin_out[XB_PIN_START]);
    assign post_raw    = posttrigger_arm_in
                         | (~board_pin_oe_n_out[XB_PIN_POST] & board_pin_out[XB_PIN_POST]);

    always_comb begin
        board_sig                 = '1;
        board_sig[XB_PIN_COUNTER1_GATE_LINE]   = counter1_gate_line_in;
        board_sig[XB_PIN_COUNTER1_OUTPUT]    = counter1_output_in;
        board_sig[XB_PIN_CONV]    = counter2_output_in & conversion_request_in_n;
        board_sig[XB_PIN_START]   = counter5_output_in & acq_begin_trigger_n_in;
        board_sig[XB_PIN_FREQ_DIVIDER_OUTPUT]    = freq_divider_output_in;
        board_sig[XB_PIN_POST]    = posttrigger_arm_in;
        board_sig[XB_PIN_COUNTER5_COUNT_INPUT] = 1'b1;
    end

    dttr_xbar #(
        .LINES (XB_LINES)
    ) u_xbar (
        .mclk_in        (mclk_in),
        .rstn_in        (rstn_in),
        .prog_sel_in    (xb_prog_sel_in),
        .prog_data_in   (xb_prog_data_in),
        .prog_wr_in     (xb_prog_wr_in),
        .board_in       (board_sig),
        .bus_in         (trig_bus_in),
        .bus_out        (trig_bus_out),
        .bus_oe_n_out   (trig_bus_oe_n_out),
        .board_out      (board_pin_out),
        .board_oe_n_out (board_pin_oe_n_out)
    );

    // ********************************************************
    // Input synchronisation
    // ********************************************************
    logic [2:0] in_rise;
    logic [2:0] in_fall;
    logic       conv_rise;
    logic       start_fall;
    logic       post_rise;

    dttr_sync_edge #(
        .W       (3),
        .RST_VAL (3'h3)
    ) u_sync (
        .mclk_in   (mclk_in),
        .rstn_in   (rstn_in),
        .d_in      ({post_raw, start_n_raw, conv_n_raw}),
        .level_out (),
        .rise_out  (in_rise),
        .fall_out  (in_fall)
    );

    assign conv_rise  = in_rise[0];
    assign start_fall = in_fall[1];
    assign post_rise  = in_rise[2];

    // ********************************************************
    // Acquisition sequence
    // ********************************************************
    dttr_acq_e        state_reg;
    dttr_acq_e        state_next;
    logic [SMP_W-1:0] smp_reg;
    logic             gate_reg;
    logic             counting;
    logic             conv_go;
    logic             tc;

    assign counting = acq_cfg_in.pretrig_mode ? gate_reg : 1'b1;
    assign conv_go  = conv_rise && state_reg == ACQ_RUN;
    assign tc       = conv_go && counting && smp_reg <= SMP_W'(1);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ACQ_IDLE: begin
                if (arm_in) begin
                    state_next = ACQ_ARMED;
                end
            end
            ACQ_ARMED: begin
                if (acq_cfg_in.ext_conv_mode) begin
                    state_next = ACQ_RUN;
                end else if (start_fall) begin
                    state_next = ACQ_RUN;
                end
            end
            ACQ_RUN: begin
                if (tc) begin
                    state_next = ACQ_IDLE;
                end
            end
            default: begin
                state_next = ACQ_IDLE;
            end
        endcase
        if (adc_clear_in) begin
            state_next = ACQ_IDLE;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            state_reg <= ACQ_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Uncascaded, only the low counter half is loaded
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            smp_reg <= '0;
        end else if (state_reg == ACQ_IDLE && arm_in) begin
            smp_reg <= acq_cfg_in.cascade ? sample_count_in
                       : {{(SMP_W-CNT_LOW_W){1'b0}}, sample_count_in[CNT_LOW_W-1:0]};
        end else if (conv_go && counting && smp_reg != '0) begin
            smp_reg <= smp_reg - 1'b1;
        end
    end

    // Set beats a clear arriving in the same cycle
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            gate_reg <= 1'b0;
        end else if (post_rise) begin
            gate_reg <= 1'b1;
        end else if (tc || overflow_in || overrun_in || adc_clear_in) begin
            gate_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            acq_busy_out           <= 1'b0;
            acq_armed_out          <= 1'b0;
            acq_done_out           <= 1'b0;
            conversion_start_out   <= 1'b0;
            counter4_gate_line_out <= 1'b0;
            sample_left_out        <= '0;
        end else begin
            acq_busy_out           <= state_next != ACQ_IDLE;
            acq_armed_out          <= state_next == ACQ_ARMED;
            acq_done_out           <= tc && !adc_clear_in;
            conversion_start_out   <= conv_go;
            counter4_gate_line_out <= gate_reg;
            sample_left_out        <= smp_reg;
        end
    end

    // ********************************************************
    // Sample-interval counter on the conversion line
    // ********************************************************
    logic [IVL_W-1:0] ivl_reg;
    logic [TMR_W-1:0] cpulse_reg;
    logic             ivl_run;

    assign ivl_run = state_reg == ACQ_RUN && !acq_cfg_in.ext_conv_mode;

    // Low pulse ends on the interval boundary, so its rising edge starts the conversion
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            ivl_reg    <= '0;
            cpulse_reg <= '0;
        end else if (!ivl_run) begin
            ivl_reg    <= interval_in - 2'h2;
            cpulse_reg <= '0;
        end else if (tick_reg) begin
            if (ivl_reg <= IVL_W'(CONV_PULSE_TICKS)) begin
                ivl_reg    <= interval_in;
                cpulse_reg <= CPULSE_LEN;
            end else begin
                ivl_reg    <= ivl_reg - 1'b1;
                cpulse_reg <= cpulse_reg == '0 ? '0 : cpulse_reg - 1'b1;
            end
        end
    end

    // Released whenever external pulses are to rule the line
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            conv_line_out      <= 1'b1;
            conv_line_oe_n_out <= 1'b1;
        end else begin
            conv_line_out      <= cpulse_reg == '0;
            conv_line_oe_n_out <= acq_cfg_in.ext_conv_mode;
        end
    end

    // ********************************************************
    // Scan marker
    // ********************************************************
    logic [TMR_W-1:0] mark_reg;
    logic [TMR_W-1:0] mark_next;

    always_comb begin
        mark_next = mark_reg;
        if (!acq_cfg_in.scan_enable) begin
            mark_next = '0;
        end else if (conv_go) begin
            mark_next = MARK_LEN;
        end else if (tick_reg && mark_reg != '0) begin
            mark_next = mark_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            mark_reg              <= '0;
            conversion_marker_out <= 1'b1;
        end else begin
            mark_reg              <= mark_next;
            conversion_marker_out <= mark_next == '0;
        end
    end

    // ********************************************************
    // Host strobe
    // ********************************************************
    logic [TMR_W-1:0] strb_reg;
    logic [TMR_W-1:0] strb_next;

    // A new access while the pulse runs stretches it rather than adding one
    always_comb begin
        strb_next = strb_reg;
        if (strobe_access_in) begin
            strb_next = STRB_LEN;
        end else if (tick_reg && strb_reg != '0) begin
            strb_next = strb_reg - 1'b1;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            strb_reg                <= '0;
            host_strobe_pulse_n_out <= 1'b1;
        end else begin
            strb_reg                <= strb_next;
            host_strobe_pulse_n_out <= strb_next == '0;
        end
    end

endmodule

/* tb/dttr_top_asserts.sv */
// Port checker for the acquisition trigger and timing router
`timescale 1ns/1ps
module dttr_top_asserts #(
    parameter int SMP_W = 32
) (
    input  wire logic               mclk_in,
    input  wire logic               rstn_in,
    input  dttr_pkg::dttr_acq_cfg_s acq_cfg_in,
    input  wire logic               overflow_in,
    input  wire logic               strobe_access_in,
    input  wire logic               conversion_request_in_n,
    input  wire logic               posttrigger_arm_in,
    input  wire logic               conv_line_oe_n_out,
    input  wire logic               conversion_marker_out,
    input  wire logic               host_strobe_pulse_n_out,
    input  wire logic               conversion_start_out,
    input  wire logic               counter4_gate_line_out,
    input  wire logic               acq_busy_out,
    input  wire logic               acq_done_out,
    input  wire logic [SMP_W-1:0]   sample_left_out,
    input  wire logic               tick_out
);
    import dttr_pkg::*;
    logic [7:0] strb_cnt;
    logic [8:0] mark_cnt;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // ****************
    // Pulse widths, conversion, completion and gate checks
    // ****************
    // Counters of low time; a restarted strobe simply keeps counting
    always_ff @(posedge mclk_in) begin
        strb_cnt <= (!rstn_in || host_strobe_pulse_n_out) ? 8'h00 : strb_cnt + 8'h01;
    end
    always_ff @(posedge mclk_in) begin
        mark_cnt <= (!rstn_in || conversion_marker_out) ? 9'h000 : mark_cnt + 9'h001;
    end
    tick_period_a: assert property (tick_out |-> ##25 tick_out) else $error("tick spacing wrong");
    marker_fall_a: assert property ($fell(conversion_marker_out) |-> conversion_start_out)
        else $error("marker fell without conversion");
    marker_idle_a: assert property (!acq_cfg_in.scan_enable [*2] |-> conversion_marker_out)
        else $error("marker low with scanning off");
    marker_width_a: assert property ($rose(conversion_marker_out) |-> mark_cnt >= 225 && mark_cnt <= 250)
        else $error("marker low time wrong");
    strobe_start_a: assert property (strobe_access_in |=> !host_strobe_pulse_n_out)
        else $error("no strobe after access");
    strobe_width_a: assert property ($rose(host_strobe_pulse_n_out) |-> strb_cnt >= 25 && strb_cnt <= 125)
        else $error("strobe width wrong");
    conv_answer_a: assert property ($rose(conversion_request_in_n) && acq_busy_out |-> ##[1:62] conversion_start_out)
        else $error("conversion not started in time");
    conv_release_a: assert property ($past(rstn_in) |-> conv_line_oe_n_out == $past(acq_cfg_in.ext_conv_mode))
        else $error("conversion line drive wrong");
    done_zero_a: assert property (acq_done_out |-> !acq_busy_out ##1 sample_left_out == '0)
        else $error("end with samples left");
    gate_set_a: assert property ($rose(posttrigger_arm_in) |-> ##[1:8] counter4_gate_line_out)
        else $error("gate not set by post edge");
    gate_clear_a: assert property (!posttrigger_arm_in [*6] ##0 overflow_in |-> ##[1:3] !counter4_gate_line_out)
        else $error("gate not cleared");
endmodule
bind dttr_top dttr_top_asserts #(.SMP_W(SMP_W)) dttr_top_asserts_i (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .acq_cfg_in(acq_cfg_in), .overflow_in(overflow_in),
    .strobe_access_in(strobe_access_in), .conversion_request_in_n(conversion_request_in_n),
    .posttrigger_arm_in(posttrigger_arm_in), .conv_line_oe_n_out(conv_line_oe_n_out),
    .conversion_marker_out(conversion_marker_out), .host_strobe_pulse_n_out(host_strobe_pulse_n_out),
    .conversion_start_out(conversion_start_out), .counter4_gate_line_out(counter4_gate_line_out),
    .acq_busy_out(acq_busy_out), .acq_done_out(acq_done_out), .sample_left_out(sample_left_out),
    .tick_out(tick_out));

/* tb/dttr_ext_src.sv */
// External trigger sources driving the router's timing pins
`timescale 1ns/1ps
module dttr_ext_src (
    input  wire logic mclk_in,
    input  wire logic conv_line_in,
    input  wire logic conv_line_oe_n_in,
    output logic      conv_n_out,
    output logic      start_n_out,
    output logic      post_out
);
    logic conv_pull_n = 1'b1;
    logic start_pull_n = 1'b1;
    // Pulled-up shared line: either party may pull it low
    assign conv_n_out = conv_pull_n & (conv_line_oe_n_in | conv_line_in);
    assign start_n_out = start_pull_n;
    initial post_out = 1'b0;
    // Low for low_cyc, then high long enough before any next fall
    task automatic pulse(input logic is_start, input int low_cyc);
        @(posedge mclk_in);
        if (is_start) start_pull_n <= 1'b0;
        else conv_pull_n <= 1'b0;
        repeat (low_cyc) @(posedge mclk_in);
        start_pull_n <= 1'b1;
        conv_pull_n <= 1'b1;
        repeat (20) @(posedge mclk_in);
    endtask
    task automatic post_set(input logic lvl);
        @(posedge mclk_in);
        post_out <= lvl;
    endtask
endmodule

/* tb/test_daq_trigger_timing_router.sv */
// Self-checking bench for the acquisition trigger and timing router
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED %0t: got %0h exp %0h", $time, got, exp); end end
module test_daq_trigger_timing_router;
    import dttr_pkg::*;
    logic mclk, rstn = 1'b0, arm = 1'b0, ovf = 1'b0, stb = 1'b0, wr = 1'b0, counter1_gate_line = 1'b0, freq = 1'b0;
    dttr_acq_cfg_s cfg = '0;
    dttr_route_s   rdata = '0;
    logic [31:0] cnt = '0, left;
    logic [15:0] ivl = '0;
    logic [3:0]  sel = '0;
    logic [6:0]  bus_drv = '0, bus_in, bus_o, bus_oe_n, pin_o, pin_oe_n;
    logic conv_o, conv_oe_n, mark, strb_n, cstart, counter4_gate_line, busy, armed, done, tick, conv_n, start_n, post;
    int n_mismatch = 0, total_checks = 0, n_conv = 0, n_done = 0, c0, k;
    // Wired-AND trigger lines, pulled up where nobody drives
    assign bus_in = bus_drv & (bus_oe_n | bus_o);
    dttr_top dttr_top_i (.mclk_in(mclk), .rstn_in(rstn), .acq_cfg_in(cfg), .arm_in(arm), .adc_clear_in(1'b0),
        .overflow_in(ovf), .overrun_in(ovf), .sample_count_in(cnt), .interval_in(ivl), .strobe_access_in(stb),
        .conversion_request_in_n(conv_n), .acq_begin_trigger_n_in(start_n), .posttrigger_arm_in(post),
        .counter1_gate_line_in(counter1_gate_line), .counter1_output_in(counter1_gate_line), .counter2_output_in(freq),
        .counter5_output_in(freq), .freq_divider_output_in(freq), .xb_prog_sel_in(sel), .xb_prog_data_in(rdata),
        .xb_prog_wr_in(wr), .trig_bus_in(bus_in), .trig_bus_out(bus_o), .trig_bus_oe_n_out(bus_oe_n),
        .board_pin_out(pin_o), .board_pin_oe_n_out(pin_oe_n), .conv_line_out(conv_o), .conv_line_oe_n_out(conv_oe_n),
        .conversion_marker_out(mark), .host_strobe_pulse_n_out(strb_n), .conversion_start_out(cstart),
        .counter4_gate_line_out(counter4_gate_line), .acq_busy_out(busy), .acq_armed_out(armed), .acq_done_out(done),
        .sample_left_out(left), .tick_out(tick));
    dttr_ext_src dttr_ext_src_i (.mclk_in(mclk), .conv_line_in(conv_o), .conv_line_oe_n_in(conv_oe_n),
        .conv_n_out(conv_n), .start_n_out(start_n), .post_out(post));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (cstart === 1'b1) n_conv <= n_conv + 1;
        if (done === 1'b1) n_done <= n_done + 1;
    end
    task automatic xb_wr(input logic [3:0] s, input logic [2:0] src);
        @(posedge mclk);
        sel <= s;
        rdata <= '{enable: 1'b1, source: src};
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic start_acq(input dttr_acq_cfg_s c, input logic [31:0] n);
        @(posedge mclk);
        cfg <= c;
        cnt <= n;
        ivl <= 16'h000C;
        arm <= 1'b1;
        @(posedge mclk);
        arm <= 1'b0;
        c0 = n_conv;
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        repeat (5) @(negedge mclk);
        `CHK(strb_n, 1'b1)
        `CHK(mark, 1'b1)
        @(posedge mclk);
        stb <= 1'b1;
        @(posedge mclk);
        stb <= 1'b0;
        k = 0;
        repeat (200) @(negedge mclk) k += (strb_n === 1'b0);
        `CHK(k >= 25 && k <= 125, 1'b1)
        start_acq(4'b0011, 32'h0000_0003);
        repeat (400) @(negedge mclk);
        `CHK(armed, 1'b1)
        `CHK(n_conv, c0)
        dttr_ext_src_i.pulse(1'b1, 13);
        for (k = 0; k < 400 && n_conv == c0; k++) @(negedge mclk);
        `CHK(k + 33 <= 12 * 25 + 2, 1'b1)
        for (k = 0; k < 3000 && n_done < 1; k++) @(negedge mclk);
        `CHK(n_conv - c0, 3)
        `CHK(left, 32'h0000_0000)
        repeat (300) @(negedge mclk);
        start_acq(4'b1100, 32'h0000_0002);
        repeat (4) @(negedge mclk);
        `CHK(conv_oe_n, 1'b1)
        dttr_ext_src_i.pulse(1'b1, 13);
        dttr_ext_src_i.pulse(1'b0, 13);
        dttr_ext_src_i.pulse(1'b0, 100);
        `CHK(left, 32'h0000_0002)
        `CHK(n_conv - c0, 2)
        dttr_ext_src_i.post_set(1'b1);
        repeat (10) @(negedge mclk);
        `CHK(counter4_gate_line, 1'b1)
        dttr_ext_src_i.pulse(1'b0, 13);
        dttr_ext_src_i.pulse(1'b0, 13);
        `CHK(n_done, 2)
        `CHK(counter4_gate_line, 1'b0)
        `CHK(mark, 1'b1)
        dttr_ext_src_i.post_set(1'b0);
        dttr_ext_src_i.post_set(1'b1);
        repeat (10) @(negedge mclk);
        dttr_ext_src_i.post_set(1'b0);
        repeat (8) @(posedge mclk);
        ovf <= 1'b1;
        @(posedge mclk);
        ovf <= 1'b0;
        repeat (4) @(negedge mclk);
        `CHK(counter4_gate_line, 1'b0)
        // Board pins take bus lines in reverse order
        @(posedge mclk) bus_drv <= 7'h35;
        for (int i = 0; i < 7; i++) xb_wr({1'b1, 3'(i)}, 3'(6 - i));
        repeat (3) @(negedge mclk);
        `CHK(pin_oe_n, 7'h00)
        `CHK(pin_o, 7'h56)
        for (int i = 0; i < 7; i++) xb_wr({1'b0, 3'(i)}, i[0] ? 3'(XB_PIN_FREQ_DIVIDER_OUTPUT) : 3'(XB_PIN_COUNTER1_GATE_LINE));
        counter1_gate_line <= 1'b1;
        repeat (3) @(negedge mclk);
        `CHK(bus_oe_n, 7'h00)
        `CHK(bus_o, 7'h55)
        @(posedge mclk);
        counter1_gate_line <= 1'b0;
        freq <= 1'b1;
        repeat (3) @(negedge mclk);
        `CHK(bus_o, 7'h2A)
        complete_run();
    end
endmodule
